// file: design/psrc_map.svh
`ifndef PSRC_MAP_SVH
`define PSRC_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define PSRC_OFS_MISC 8'h40
`define PSRC_OFS_PERIPH 8'h44

// ****************************************
// reset values and writable bits
// ****************************************
`define PSRC_RST_MISC 32'h0000_0000
`define PSRC_RST_PERIPH 32'h0000_0000
`define PSRC_WR_MASK_MISC 32'h0001_0048
`define PSRC_WR_MASK_PERIPH 32'h070F_5137
`define PSRC_READ_ZERO 32'h0000_0000

// ****************************************
// field positions, misc register
// ****************************************
`define PSRC_BIT_CONV 16
`define PSRC_BIT_SLEEP 6
`define PSRC_BIT_WDOG 3

// ****************************************
// field positions, peripheral register
// ****************************************
`define PSRC_BIT_CMP_LO 24
`define PSRC_BIT_CMP_HI 26
`define PSRC_BIT_GPC_LO 16
`define PSRC_BIT_GPC_HI 19
`define PSRC_BIT_TWU1 14
`define PSRC_BIT_TWU0 12
`define PSRC_BIT_QDEC 8
`define PSRC_BIT_SSER_LO 4
`define PSRC_BIT_SSER_HI 5
`define PSRC_BIT_ASER_LO 0
`define PSRC_BIT_ASER_HI 2

`endif

// file: design/psrc_pkg.sv
package psrc_pkg;

  // wishbone request as seen by the slave
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } psrc_wb_req_s;

  // per-peripheral reset lines, high holds the unit in reset
  typedef struct packed {
    logic conv_zero_reset;
    logic sleep_power_unit_reset_bit;
    logic watchdog_reset_bit;
    logic [2:0] analog_comparator_reset;
    logic [3:0] gp_counter_reset;
    logic two_wire_unit_one_reset;
    logic two_wire_unit_zero_reset;
    logic quadrature_decoder_reset;
    logic [1:0] sync_serial_reset;
    logic [2:0] async_serial_reset;
  } psrc_resets_s;

  typedef enum logic {
    PSRC_IDLE = 1'b0,
    PSRC_ACK = 1'b1
  } psrc_bus_state_e;

endpackage

// file: design/psrc_wb_slave.sv
`timescale 1ns/10ps
`include "psrc_map.svh"

module psrc_wb_slave (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus request
  input psrc_pkg::psrc_wb_req_s req,
  // decoded answer
  output logic ack,
  output logic take_read,
  output logic commit_misc,
  output logic commit_periph
);

  // ****************************************
  // handshake state
  // ****************************************
  psrc_pkg::psrc_bus_state_e state_reg;
  psrc_pkg::psrc_bus_state_e state_next;
  logic active;

  assign active = req.cyc & req.stb;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      psrc_pkg::PSRC_IDLE: begin
        if (active) begin
          state_next = psrc_pkg::PSRC_ACK;
        end
      end
      // ack lasts one cycle, then drops even if stb lingers
      psrc_pkg::PSRC_ACK: begin
        state_next = psrc_pkg::PSRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= psrc_pkg::PSRC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  assign ack = (state_reg == psrc_pkg::PSRC_ACK);
  assign take_read = active & (state_reg == psrc_pkg::PSRC_IDLE);
  // writes land on the edge where the master sees ack
  assign commit_misc = ack & active & req.we & (req.adr == `PSRC_OFS_MISC);
  assign commit_periph = ack & active & req.we & (req.adr == `PSRC_OFS_PERIPH);

endmodule

// file: design/psrc_ctrl.sv
// Function
// - misc writes masked by first capabilities
// - peripheral writes masked by second capabilities
// - misc register at 0x040, RW, resets zero
// - peripheral register at 0x044, RW, resets zero
// - misc bit 16 resets converter zero
// - misc bit 6 resets sleep power unit
// - misc bit 3 resets watchdog
// - reserved bits read-only, read zero
// - bits 26..24 reset comparators two..zero
// - bits 19..16 reset counters three..zero
// - bit 14 two-wire one, 12 zero
// - bit 8 resets quadrature decoder
// - bits 5,4 reset sync serial one,zero
// - bits 2..0 reset async serial two..zero
`timescale 1ns/10ps
`include "psrc_map.svh"

module psrc_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // present-unit masks from the capabilities block
  input wire logic [31:0] capabilities_reg_one,
  input wire logic [31:0] capabilities_reg_two,
  // peripheral reset lines
  output psrc_pkg::psrc_resets_s resets
);

  // ****************************************
  // bus front end
  // ****************************************
  psrc_pkg::psrc_wb_req_s req;
  logic take_read;
  logic commit_misc;
  logic commit_periph;

  assign req.cyc = wb_cyc_i;
  assign req.stb = wb_stb_i;
  assign req.we = wb_we_i;
  assign req.sel = wb_sel_i;
  assign req.adr = wb_adr_i;
  assign req.dat = wb_dat_i;

  psrc_wb_slave u_slave (
    .clk(clk),
    .rst(rst),
    .req(req),
    .ack(wb_ack_o),
    .take_read(take_read),
    .commit_misc(commit_misc),
    .commit_periph(commit_periph)
  );

  // ****************************************
  // write masks
  // ****************************************
  logic [31:0] lane_mask;
  logic [31:0] eff_misc;
  logic [31:0] eff_periph;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{wb_sel_i[lane]}};
    end
  endgenerate

  // absent units and reserved bits can never be written
  assign eff_misc = lane_mask & capabilities_reg_one & `PSRC_WR_MASK_MISC;
  assign eff_periph = lane_mask & capabilities_reg_two & `PSRC_WR_MASK_PERIPH;

  // ****************************************
  // control registers
  // ****************************************
  logic [31:0] misc_reg;
  logic [31:0] misc_next;
  logic [31:0] periph_reg;
  logic [31:0] periph_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    misc_next = misc_reg;
    periph_next = periph_reg;
    if (commit_misc) begin
      misc_next = (misc_reg & ~eff_misc) | (wb_dat_i & eff_misc);
    end
    if (commit_periph) begin
      periph_next = (periph_reg & ~eff_periph) | (wb_dat_i & eff_periph);
    end
  end

  // read data is captured on the request edge so it is a flop output
  always_comb begin
    rdata_next = rdata_reg;
    if (take_read) begin
      unique case (wb_adr_i)
        `PSRC_OFS_MISC: rdata_next = misc_reg;
        `PSRC_OFS_PERIPH: rdata_next = periph_reg;
        default: rdata_next = `PSRC_READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      misc_reg <= `PSRC_RST_MISC;
      periph_reg <= `PSRC_RST_PERIPH;
      rdata_reg <= `PSRC_READ_ZERO;
    end else begin
      misc_reg <= misc_next;
      periph_reg <= periph_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_dat_o = rdata_reg;

  // ****************************************
  // reset fan-out
  // ****************************************
  // lines come straight from the register flops: no glitches into units
  assign resets.conv_zero_reset = misc_reg[`PSRC_BIT_CONV];
  assign resets.sleep_power_unit_reset_bit = misc_reg[`PSRC_BIT_SLEEP];
  assign resets.watchdog_reset_bit = misc_reg[`PSRC_BIT_WDOG];
  assign resets.analog_comparator_reset =
    periph_reg[`PSRC_BIT_CMP_HI:`PSRC_BIT_CMP_LO];
  assign resets.gp_counter_reset = periph_reg[`PSRC_BIT_GPC_HI:`PSRC_BIT_GPC_LO];
  assign resets.two_wire_unit_one_reset = periph_reg[`PSRC_BIT_TWU1];
  assign resets.two_wire_unit_zero_reset = periph_reg[`PSRC_BIT_TWU0];
  assign resets.quadrature_decoder_reset = periph_reg[`PSRC_BIT_QDEC];
  assign resets.sync_serial_reset =
    periph_reg[`PSRC_BIT_SSER_HI:`PSRC_BIT_SSER_LO];
  assign resets.async_serial_reset =
    periph_reg[`PSRC_BIT_ASER_HI:`PSRC_BIT_ASER_LO];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic wr_m;
  logic wr_p;
  assign wr_m = commit_misc;
  assign wr_p = commit_periph;

  chk_misc_cap_mask: assert property (
    ((misc_reg & ~$past(misc_reg) & ~$past(capabilities_reg_one)) == 32'h0000_0000))
    else $error("misc bit rose for an absent unit");

  chk_periph_cap_mask: assert property (
    ((periph_reg & ~$past(periph_reg) & ~$past(capabilities_reg_two)) == 32'h0000_0000))
    else $error("peripheral bit rose for an absent unit");

  chk_misc_after_reset: assert property (
    $past(rst) |-> (misc_reg == `PSRC_RST_MISC) && (resets == '0))
    else $error("misc register not zero after reset");

  chk_periph_after_reset: assert property (
    $past(rst) |-> periph_reg == `PSRC_RST_PERIPH)
    else $error("peripheral register not zero after reset");

  chk_conv_set: assert property (
    wr_m && wb_sel_i[2] && wb_dat_i[16] && capabilities_reg_one[16]
    |=> resets.conv_zero_reset)
    else $error("converter reset not taken");

  chk_sleep_set: assert property (
    wr_m && wb_sel_i[0] && wb_dat_i[6] && capabilities_reg_one[6]
    |=> resets.sleep_power_unit_reset_bit)
    else $error("sleep unit reset not taken");

  chk_wdog_set: assert property (
    wr_m && wb_sel_i[0] && wb_dat_i[3] && capabilities_reg_one[3]
    |=> resets.watchdog_reset_bit)
    else $error("watchdog reset not taken");

  chk_reserved_zero: assert property (
    ((misc_reg & ~`PSRC_WR_MASK_MISC) == 32'h0000_0000)
    && ((periph_reg & ~`PSRC_WR_MASK_PERIPH) == 32'h0000_0000))
    else $error("reserved bit holds one");

  chk_cmp_set: assert property (
    wr_p && wb_sel_i[3] && wb_dat_i[24] && capabilities_reg_two[24]
    |=> resets.analog_comparator_reset[0])
    else $error("comparator zero reset not taken");

  chk_gpc_set: assert property (
    wr_p && wb_sel_i[2] && wb_dat_i[19] && capabilities_reg_two[19]
    |=> resets.gp_counter_reset[3])
    else $error("counter three reset not taken");

  chk_twu_set: assert property (
    wr_p && wb_sel_i[1] && wb_dat_i[12] && capabilities_reg_two[12]
    |=> resets.two_wire_unit_zero_reset)
    else $error("two-wire zero reset not taken");

  chk_qdec_set: assert property (
    wr_p && wb_sel_i[1] && wb_dat_i[8] && capabilities_reg_two[8]
    |=> resets.quadrature_decoder_reset)
    else $error("quadrature reset not taken");

  chk_sser_set: assert property (
    wr_p && wb_sel_i[0] && wb_dat_i[5] && capabilities_reg_two[5]
    |=> resets.sync_serial_reset[1])
    else $error("sync serial one reset not taken");

  chk_aser_set: assert property (
    wr_p && wb_sel_i[0] && wb_dat_i[2] && capabilities_reg_two[2]
    |=> resets.async_serial_reset[2])
    else $error("async serial two reset not taken");

  chk_release_hold: assert property (
    wr_p && wb_sel_i[0] && !wb_dat_i[0] && capabilities_reg_two[0]
    |=> !resets.async_serial_reset[0] [*2])
    else $error("async serial zero not released");

  chk_cmp_two_set: assert property (
    wr_p && wb_sel_i[3] && wb_dat_i[26] && capabilities_reg_two[26]
    |=> resets.analog_comparator_reset[2])
    else $error("comparator two reset not taken");

  chk_cmp_one_set: assert property (
    wr_p && wb_sel_i[3] && wb_dat_i[25] && capabilities_reg_two[25]
    |=> resets.analog_comparator_reset[1])
    else $error("comparator one reset not taken");

  chk_gpc_zero_set: assert property (
    wr_p && wb_sel_i[2] && wb_dat_i[16] && capabilities_reg_two[16]
    |=> resets.gp_counter_reset[0])
    else $error("counter zero reset not taken");

  chk_gpc_one_set: assert property (
    wr_p && wb_sel_i[2] && wb_dat_i[17] && capabilities_reg_two[17]
    |=> resets.gp_counter_reset[1])
    else $error("counter one reset not taken");

  chk_gpc_two_set: assert property (
    wr_p && wb_sel_i[2] && wb_dat_i[18] && capabilities_reg_two[18]
    |=> resets.gp_counter_reset[2])
    else $error("counter two reset not taken");

  chk_twu_one_set: assert property (
    wr_p && wb_sel_i[1] && wb_dat_i[14] && capabilities_reg_two[14]
    |=> resets.two_wire_unit_one_reset)
    else $error("two-wire one reset not taken");

  chk_sser_zero_set: assert property (
    wr_p && wb_sel_i[0] && wb_dat_i[4] && capabilities_reg_two[4]
    |=> resets.sync_serial_reset[0])
    else $error("sync serial zero reset not taken");

  chk_aser_zero_set: assert property (
    wr_p && wb_sel_i[0] && wb_dat_i[0] && capabilities_reg_two[0]
    |=> resets.async_serial_reset[0])
    else $error("async serial zero reset not taken");

  chk_aser_one_set: assert property (
    wr_p && wb_sel_i[0] && wb_dat_i[1] && capabilities_reg_two[1]
    |=> resets.async_serial_reset[1])
    else $error("async serial one reset not taken");

  chk_wdog_release: assert property (
    wr_m && wb_sel_i[0] && !wb_dat_i[3] && capabilities_reg_one[3]
    |=> !resets.watchdog_reset_bit)
    else $error("watchdog not released");

  chk_periph_masked_hold: assert property (
    wr_p && wb_sel_i[0] && !capabilities_reg_two[0]
    |=> $stable(resets.async_serial_reset[0]))
    else $error("absent async serial zero line moved");

  chk_misc_masked_hold: assert property (
    wr_m && wb_sel_i[0] && !capabilities_reg_one[3]
    |=> $stable(resets.watchdog_reset_bit))
    else $error("absent watchdog line moved");

  chk_hold_no_write: assert property (
    !wr_m && !wr_p |=> $stable(misc_reg) && $stable(periph_reg))
    else $error("reset line moved without a write");

  chk_ack_pulse: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not a single-cycle answer");

  chk_read_back: assert property (
    take_read && (wb_adr_i == `PSRC_OFS_PERIPH) |=> wb_dat_o == $past(periph_reg))
    else $error("read data wrong");

  cov_misc_write: cover property (wr_m ##1 resets.watchdog_reset_bit);
  cov_periph_write: cover property (wr_p ##1 (resets.gp_counter_reset != 4'h0));
  cov_masked_write: cover property (wr_p && !capabilities_reg_two[0] && wb_dat_i[0]);
  cov_unmapped: cover property (take_read && (wb_adr_i == 8'h48));

endmodule

// file: verification/psrc_periph_model.sv
`timescale 1ns/10ps

// ****************************************
// far side: the units whose reset inputs the block drives
// ****************************************
module psrc_periph_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // reset lines from the block
  input psrc_pkg::psrc_resets_s resets,
  // units currently held, one cycle after the line
  output logic [17:0] held
);
  logic [17:0] held_reg;
  logic [17:0] held_next;

  // a unit sees its reset line only at its own clock edge
  always_comb begin
    held_next = rst ? 18'h0_0000 : resets;
  end

  always_ff @(posedge clk) begin
    held_reg <= held_next;
  end

  assign held = held_reg;
endmodule

// file: verification/peripheral_soft_reset_ctrl_tb_top.sv
`timescale 1ns/10ps
`include "psrc_map.svh"

module peripheral_soft_reset_ctrl_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [31:0] cap1 = 32'hFFFF_FFFF;
  logic [31:0] cap2 = 32'hFFFF_FFFF;
  psrc_pkg::psrc_resets_s resets;
  logic [17:0] held;
  logic [31:0] exp_misc = 32'h0000_0000;
  logic [31:0] exp_per = 32'h0000_0000;
  int err_count = 0;
  int n_compared = 0;
  logic [7:0] adrs [3] = '{8'h40, 8'h44, 8'h48};

  always #50 clk = ~clk;

  psrc_ctrl u_dut (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .capabilities_reg_one(cap1), .capabilities_reg_two(cap2), .resets(resets)
  );

  psrc_periph_model u_model (.clk(clk), .rst(rst), .resets(resets), .held(held));

  task automatic give_verdict();
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp18(input logic [17:0] got, input logic [17:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [17:0] exp_rst(input logic [31:0] m, input logic [31:0] p);
    return {m[16], m[6], m[3], p[26:24], p[19:16], p[14], p[12], p[8], p[5:4], p[2:0]};
  endfunction

  function automatic logic [31:0] upd(input logic [31:0] old, input logic [31:0] d,
                                      input logic [31:0] k, input logic [3:0] sel);
    logic [31:0] m;
    m = k & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  // classic single cycle; no fixed latency assumed, only a bounded wait
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
                         input logic [3:0] sel, output logic [31:0] q);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      err_count++;
      give_verdict();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] q;
    wb_xfer(1'b1, adr, d, sel, q);
    if (adr == 8'h40) begin
      exp_misc = upd(exp_misc, d, `PSRC_WR_MASK_MISC & cap1, sel);
    end
    if (adr == 8'h44) begin
      exp_per = upd(exp_per, d, `PSRC_WR_MASK_PERIPH & cap2, sel);
    end
  endtask

  task automatic chk_all();
    logic [31:0] q;
    wb_xfer(1'b0, 8'h40, 32'h0000_0000, 4'hF, q);
    cmp32(q, exp_misc);
    wb_xfer(1'b0, 8'h44, 32'h0000_0000, 4'hF, q);
    cmp32(q, exp_per);
    wb_xfer(1'b0, 8'h48, 32'h0000_0000, 4'hF, q);
    cmp32(q, 32'h0000_0000);
    cmp18(resets, exp_rst(exp_misc, exp_per));
  endtask

  initial begin
    void'($urandom(55));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_all();
    // walking one through every bit of both registers, all units present
    for (int i = 0; i < 32; i++) begin
      wr(8'h40, 32'h0000_0001 << i, 4'hF);
      wr(8'h44, 32'h0000_0001 << i, 4'hF);
      chk_all();
    end
    // random capabilities, lanes and addresses, unmapped one included
    for (int i = 0; i < 60; i++) begin
      cap1 <= $urandom();
      cap2 <= $urandom();
      wr(adrs[$urandom() % 3], $urandom(), 4'($urandom()));
      chk_all();
    end
    cap1 <= 32'hFFFF_FFFF;
    cap2 <= 32'hFFFF_FFFF;
    wr(8'h40, 32'hFFFF_FFFF, 4'hF);
    wr(8'h44, 32'hFFFF_FFFF, 4'hF);
    chk_all();
    cmp18(held, 18'h3_FFFF);
    wr(8'h40, 32'h0000_0000, 4'hF);
    wr(8'h44, 32'h0000_0000, 4'hF);
    chk_all();
    cmp18(held, 18'h0_0000);
    wr(8'h40, 32'hFFFF_FFFF, 4'hF);
    wr(8'h44, 32'hFFFF_FFFF, 4'hF);
    // a reset in mid-run must drop every line, whatever software had set
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    exp_misc = `PSRC_RST_MISC;
    exp_per = `PSRC_RST_PERIPH;
    cmp18(held, 18'h0_0000);
    chk_all();
    give_verdict();
  end
endmodule
